/* design/ttcr_pkg.sv */
// Constants and carrier types for the test traffic control register bank.
// Assumes a single system clock and a plain strobe register port.
package ttcr_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses on the 8-bit register port)
	// ----------------------------------------------------------------
	localparam int          ADDR_W              = 8;      // Address width.
	localparam int          DATA_W              = 32;     // Data width.
	localparam logic [7:0]  ADDR_USER_RESET     = 8'h00;  // Soft reset, link.
	localparam logic [7:0]  ADDR_USER_COMMAND   = 8'h04;  // Test command.
	localparam logic [7:0]  ADDR_TX_BYTE_COUNT  = 8'h08;  // Tx length/count.
	localparam logic [7:0]  ADDR_RX_BYTE_COUNT  = 8'h0C;  // Rx byte count.
	localparam logic [7:0]  ADDR_TX_START_ADDR  = 8'h20;  // Tx engine addr.
	localparam logic [7:0]  ADDR_TX_LENGTH      = 8'h24;  // Tx engine length.
	localparam logic [7:0]  ADDR_TX_COMMAND     = 8'h28;  // Tx engine command.
	localparam logic [7:0]  ADDR_RX_POINTER     = 8'h30;  // Rx ring pointers.
	localparam logic [7:0]  ADDR_RX_COMMAND     = 8'h34;  // Rx engine command.

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RST_SOFT_BIT   = 0;   // Write 1 clears pattern logic.
	localparam int RST_LINK_BIT   = 16;  // Link up status.
	localparam int CMD_DUPLEX_BIT = 0;   // Full-duplex test.
	localparam int CMD_VERIFY_BIT = 1;   // Verify enable / error on read.
	localparam int CMD_CONN_BIT   = 2;   // Connection on.
	localparam int ENG_START_BIT  = 0;   // Engine start / busy.
	localparam int ENG_FINISH_BIT = 31;  // Engine finish flag.
	localparam int PTR_WRITE_LSB  = 0;   // Rx write pointer field.
	localparam int PTR_READ_LSB   = 8;   // Rx read pointer field.
	localparam int PTR_FULL_BIT   = 16;  // Rx ring full.

	// ----------------------------------------------------------------
	// Widths, reset values and counts
	// ----------------------------------------------------------------
	localparam int          PTR_W          = 4;       // Ring pointer width.
	localparam logic [3:0]  PTR_FULL_GAP   = 4'h8;    // Pointer gap at full.
	localparam logic [3:0]  PTR_RESET      = 4'h0;    // Pointer reset value.
	localparam logic [31:0] BYTES_PER_WORD = 32'h4;   // Bytes per data word.
	localparam logic [31:0] PATTERN_RESET  = 32'h0;   // First pattern word.
	localparam logic [31:0] WORD_RESET     = 32'h0;   // Register reset value.

	// One beat of the 32-bit data stream.
	typedef struct packed {
		logic        valid;  // Word present.
		logic [31:0] data;   // Data word.
	} ttcr_beat_t;

endpackage : ttcr_pkg

/* design/ttcr_regs.sv */
// Register bank that runs the traffic tests and the slow-port engines.
// Assumes the offload core, the engines and the CPU share clk_sys.
//
// What this block does
// - Generate and verify 32-bit incrementing data
// - Soft reset bit clears pattern logic
// - Command bit 2 shows connection state
// - Command bit 1 reads verification error
// - Ring full at gap 8, blocks storing
// - Tx bit 31 finish, write 1 clears
// - Rx bit 31 finish, write 1 clears
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module ttcr_regs (
	input  wire logic                clk_sys,     // System clock, 10 MHz.
	input  wire logic                reset_n,     // Async reset, active low.
	input  wire logic [7:0]          regAddr,     // Register byte address.
	input  wire logic [31:0]         regWrData,   // Write data.
	input  wire logic                regWr,       // Write strobe.
	input  wire logic                regRd,       // Read strobe.
	output var  logic [31:0]         regRdData,   // Read data, next cycle.
	input  wire logic                linkUp,      // Ethernet link is up.
	input  wire logic                connOn,      // Connection is open.
	output var  logic                closeReq,    // Close the connection.
	output var  ttcr_pkg::ttcr_beat_t txBeat,     // Pattern to offload core.
	input  wire logic                txReady,     // Offload core takes word.
	input  wire ttcr_pkg::ttcr_beat_t rxBeat,     // Data from offload core.
	output var  logic                txEngStart,  // Tx engine start pulse.
	output var  logic [31:0]         txEngAddr,   // Tx engine start address.
	output var  logic [31:0]         txEngLen,    // Tx engine length.
	input  wire logic                txEngDone,   // Tx engine finished pulse.
	input  wire logic                rxPktEnd,    // Rx engine ends a packet.
	output var  logic                rxStoreEn,   // Rx ring may store.
	output var  logic [3:0]          rxRdPtr      // Rx ring read pointer.
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic        genRun,    next_genRun;     // Generator enabled.
	logic        duplex,    next_duplex;     // Full-duplex test active.
	logic        verifyEn,  next_verifyEn;   // Verification enabled.
	logic        verifyErr, next_verifyErr;  // Mismatch seen, sticky.
	logic [31:0] txLen,     next_txLen;      // Requested transmit bytes.
	logic [31:0] txCount,   next_txCount;    // Bytes handed over.
	logic [31:0] rxCount,   next_rxCount;    // Bytes received.
	logic [31:0] rxPat,     next_rxPat;      // Expected receive word.
	logic        txBusy,    next_txBusy;     // Tx engine running.
	logic        txFinish,  next_txFinish;   // Tx engine finished, sticky.
	logic        rxFinish,  next_rxFinish;   // Rx packet stored, sticky.
	logic [3:0]  rxWrPtr,   next_rxWrPtr;    // Rx ring write pointer.
	logic [31:0] next_regRdData;             // Read data to present.
	logic        next_closeReq;              // Close request.
	logic        next_txEngStart;            // Engine start pulse.
	logic [31:0] next_txEngAddr;             // Engine address.
	logic [31:0] next_txEngLen;              // Engine length.
	logic        next_rxStoreEn;             // Ring not full.
	logic [3:0]  next_rxRdPtr;               // Ring read pointer.
	ttcr_pkg::ttcr_beat_t next_txBeat;       // Next pattern beat.

	// Decoded strobes for the logic, some also used by the checks; wrCmd is used by neither.
	logic softClr;   // Pattern logic clear request.
	logic txFire;    // Pattern word accepted.
	logic rxFull;    // Ring full now.
	logic rxStore;   // Packet end taken into the ring.
	logic wrCmd;     // Write to the user command register.
	logic rxMis;     // Received word differs while verifying.

	assign softClr = regWr && regAddr == ttcr_pkg::ADDR_USER_RESET
		&& regWrData[ttcr_pkg::RST_SOFT_BIT];
	assign txFire  = txBeat.valid && txReady;
	assign rxFull  = 4'(rxWrPtr - rxRdPtr) == ttcr_pkg::PTR_FULL_GAP;
	assign rxStore = rxPktEnd && !rxFull;
	assign wrCmd   = regWr && regAddr == ttcr_pkg::ADDR_USER_COMMAND;
	assign rxMis   = rxBeat.valid && verifyEn && rxBeat.data != rxPat;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Computes every register's next value but the read data from the bus and the streams.
	always_comb begin
		next_genRun     = genRun;
		next_duplex     = duplex;
		next_verifyEn   = verifyEn;
		next_verifyErr  = verifyErr;
		next_txLen      = txLen;
		next_txCount    = txCount;
		next_rxCount    = rxCount;
		next_rxPat      = rxPat;
		next_txBeat     = txBeat;
		next_txBusy     = txBusy;
		next_txFinish   = txFinish;
		next_rxFinish   = rxFinish;
		next_rxWrPtr    = rxWrPtr;
		next_rxRdPtr    = rxRdPtr;
		next_txEngAddr  = txEngAddr;
		next_txEngLen   = txEngLen;
		next_txEngStart = 1'b0;
		next_closeReq   = closeReq && connOn;
		// Transmit pattern: advance on each accepted word.
		if (txFire) begin
			next_txCount     = txCount + ttcr_pkg::BYTES_PER_WORD;
			next_txBeat.data = txBeat.data + 32'h1;
		end
		next_txBeat.valid = genRun && next_txCount < txLen;
		// Receive check against the same incrementing sequence.
		if (rxBeat.valid) begin
			next_rxCount = rxCount + ttcr_pkg::BYTES_PER_WORD;
			next_rxPat   = rxPat + 32'h1;
			if (rxMis) begin
				next_verifyErr = 1'b1;
			end
		end
		// Register writes.
		if (regWr) begin
			unique case (regAddr)
				ttcr_pkg::ADDR_USER_COMMAND: begin
					// A write of 3 during a running duplex test closes.
					if (genRun && duplex && connOn
						&& regWrData[1:0] == 2'h3) begin
						next_closeReq = 1'b1;
					end else begin
						next_genRun   = 1'b1;
						next_duplex   = regWrData[ttcr_pkg::CMD_DUPLEX_BIT];
						next_verifyEn = regWrData[ttcr_pkg::CMD_VERIFY_BIT];
					end
				end
				ttcr_pkg::ADDR_TX_BYTE_COUNT: begin
					next_txLen = regWrData;
				end
				ttcr_pkg::ADDR_TX_START_ADDR: begin
					next_txEngAddr = regWrData;
				end
				ttcr_pkg::ADDR_TX_LENGTH: begin
					next_txEngLen = regWrData;
				end
				ttcr_pkg::ADDR_TX_COMMAND: begin
					if (regWrData[ttcr_pkg::ENG_START_BIT] && !txBusy) begin
						next_txEngStart = 1'b1;
						next_txBusy     = 1'b1;
					end
					if (regWrData[ttcr_pkg::ENG_FINISH_BIT]) begin
						next_txFinish = 1'b0;
					end
				end
				ttcr_pkg::ADDR_RX_POINTER: begin
					next_rxRdPtr = regWrData[ttcr_pkg::PTR_READ_LSB +: 4];
				end
				ttcr_pkg::ADDR_RX_COMMAND: begin
					if (regWrData[ttcr_pkg::ENG_FINISH_BIT]) begin
						next_rxFinish = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Engine events; a set beats a clear in the same cycle.
		if (txEngDone && txBusy) begin
			next_txBusy   = 1'b0;
			next_txFinish = 1'b1;
		end
		if (rxStore) begin
			next_rxWrPtr  = 4'(rxWrPtr + 4'h1);
			next_rxFinish = 1'b1;
		end
		next_rxStoreEn = 4'(next_rxWrPtr - next_rxRdPtr)
			!= ttcr_pkg::PTR_FULL_GAP;
		// Soft reset returns the pattern logic to its start.
		if (softClr) begin
			next_genRun    = 1'b0;
			next_verifyErr = rxMis;  // A mismatch in this cycle wins.
			next_txCount   = ttcr_pkg::WORD_RESET;
			next_rxCount   = ttcr_pkg::WORD_RESET;
			next_rxPat     = ttcr_pkg::PATTERN_RESET;
			next_txBeat    = '{valid: 1'b0, data: ttcr_pkg::PATTERN_RESET};
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Builds the answer for a read; zero outside a read and when unmapped.
	always_comb begin
		next_regRdData = ttcr_pkg::WORD_RESET;
		if (regRd) begin
			unique case (regAddr)
				ttcr_pkg::ADDR_USER_RESET: begin
					next_regRdData[ttcr_pkg::RST_LINK_BIT] = linkUp;
				end
				ttcr_pkg::ADDR_USER_COMMAND: begin
					next_regRdData[ttcr_pkg::CMD_DUPLEX_BIT] = genRun;
					next_regRdData[ttcr_pkg::CMD_VERIFY_BIT] = verifyErr;
					next_regRdData[ttcr_pkg::CMD_CONN_BIT]   = connOn;
				end
				ttcr_pkg::ADDR_TX_BYTE_COUNT: next_regRdData = txCount;
				ttcr_pkg::ADDR_RX_BYTE_COUNT: next_regRdData = rxCount;
				ttcr_pkg::ADDR_TX_START_ADDR: next_regRdData = txEngAddr;
				ttcr_pkg::ADDR_TX_LENGTH:     next_regRdData = txEngLen;
				ttcr_pkg::ADDR_TX_COMMAND: begin
					next_regRdData[ttcr_pkg::ENG_START_BIT]  = txBusy;
					next_regRdData[ttcr_pkg::ENG_FINISH_BIT] = txFinish;
				end
				ttcr_pkg::ADDR_RX_POINTER: begin
					next_regRdData[ttcr_pkg::PTR_WRITE_LSB +: 4] = rxWrPtr;
					next_regRdData[ttcr_pkg::PTR_READ_LSB +: 4]  = rxRdPtr;
					next_regRdData[ttcr_pkg::PTR_FULL_BIT]       = rxFull;
				end
				ttcr_pkg::ADDR_RX_COMMAND: begin
					next_regRdData[ttcr_pkg::ENG_FINISH_BIT] = rxFinish;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Registers every next value; reset puts all control state at rest.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			genRun     <= 1'b0;
			duplex     <= 1'b0;
			verifyEn   <= 1'b0;
			verifyErr  <= 1'b0;
			txLen      <= ttcr_pkg::WORD_RESET;
			txCount    <= ttcr_pkg::WORD_RESET;
			rxCount    <= ttcr_pkg::WORD_RESET;
			rxPat      <= ttcr_pkg::PATTERN_RESET;
			txBeat     <= '{valid: 1'b0, data: ttcr_pkg::PATTERN_RESET};
			txBusy     <= 1'b0;
			txFinish   <= 1'b0;
			rxFinish   <= 1'b0;
			rxWrPtr    <= ttcr_pkg::PTR_RESET;
			rxRdPtr    <= ttcr_pkg::PTR_RESET;
			rxStoreEn  <= 1'b1;
			txEngAddr  <= ttcr_pkg::WORD_RESET;
			txEngLen   <= ttcr_pkg::WORD_RESET;
			txEngStart <= 1'b0;
			closeReq   <= 1'b0;
			regRdData  <= ttcr_pkg::WORD_RESET;
		end else begin
			genRun     <= next_genRun;
			duplex     <= next_duplex;
			verifyEn   <= next_verifyEn;
			verifyErr  <= next_verifyErr;
			txLen      <= next_txLen;
			txCount    <= next_txCount;
			rxCount    <= next_rxCount;
			rxPat      <= next_rxPat;
			txBeat     <= next_txBeat;
			txBusy     <= next_txBusy;
			txFinish   <= next_txFinish;
			rxFinish   <= next_rxFinish;
			rxWrPtr    <= next_rxWrPtr;
			rxRdPtr    <= next_rxRdPtr;
			rxStoreEn  <= next_rxStoreEn;
			txEngAddr  <= next_txEngAddr;
			txEngLen   <= next_txEngLen;
			txEngStart <= next_txEngStart;
			closeReq   <= next_closeReq;
			regRdData  <= next_regRdData;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// A start write on an idle engine, then the single start pulse.
	sequence txStartWrite;
		regWr && regAddr == ttcr_pkg::ADDR_TX_COMMAND
			&& regWrData[ttcr_pkg::ENG_START_BIT] && !txBusy && !txEngDone;
	endsequence
	sequence txStartPulse;
		txEngStart && txBusy ##1 !txEngStart;
	endsequence

	a_gen_increment: assert property (
		txFire && !softClr |=> txBeat.data == $past(txBeat.data) + 32'h1)
		else $error("pattern word did not increment");
	a_verify_mismatch: assert property (
		rxMis |=> verifyErr)
		else $error("mismatch not flagged");
	a_soft_clear: assert property (
		softClr |=> !txBeat.valid && txBeat.data == ttcr_pkg::PATTERN_RESET
			&& rxPat == ttcr_pkg::PATTERN_RESET
			&& verifyErr == $past(rxMis))
		else $error("soft reset left pattern state");
	a_conn_readback: assert property (
		regRd && regAddr == ttcr_pkg::ADDR_USER_COMMAND
		|=> regRdData[ttcr_pkg::CMD_CONN_BIT] == $past(connOn))
		else $error("connection bit wrong");
	a_error_readback: assert property (
		regRd && regAddr == ttcr_pkg::ADDR_USER_COMMAND
		|=> regRdData[ttcr_pkg::CMD_VERIFY_BIT] == $past(verifyErr))
		else $error("error bit wrong");
	a_ring_full_hold: assert property (
		rxPktEnd && 4'(rxWrPtr - rxRdPtr) == 4'h8 |=> $stable(rxWrPtr))
		else $error("stored into a full ring");
	a_ring_advance: assert property (
		rxPktEnd && 4'(rxWrPtr - rxRdPtr) != 4'h8
		|=> rxWrPtr == 4'($past(rxWrPtr) + 4'h1) && rxFinish)
		else $error("ring did not advance");
	a_tx_start_once: assert property (
		txStartWrite |=> txStartPulse)
		else $error("engine start not a single pulse");
	a_tx_finish_set: assert property (
		txEngDone && txBusy |=> txFinish && !txBusy)
		else $error("tx finish flag not set");

endmodule : ttcr_regs

`default_nettype wire

/* tb/test_ttcr_regs.sv */
// Self-checking testbench for the test traffic control register bank.
// Assumes the design carries its own assertions; the bench drives all ports.
`timescale 1ns/1ns
`default_nettype none

module test_ttcr_regs;
	// ----------------------------------------------------------------
	// Signals and counters
	// ----------------------------------------------------------------
	logic                 clk_sys;    // System clock, 100 ns period.
	logic                 reset_n;    // Async reset, active low.
	logic [7:0]           regAddr;    // Register address.
	logic [31:0]          regWrData;  // Write data.
	logic                 regWr;      // Write strobe.
	logic                 regRd;      // Read strobe.
	logic [31:0]          regRdData;  // Read data.
	logic                 linkUp;     // Link status in.
	logic                 connOn;     // Connection status in.
	logic                 closeReq;   // Close request out.
	ttcr_pkg::ttcr_beat_t txBeat;     // Pattern stream out.
	logic                 txReady;    // Pattern stream ready.
	ttcr_pkg::ttcr_beat_t rxBeat;     // Received stream in.
	logic                 txEngStart; // Tx engine start pulse.
	logic [31:0]          txEngAddr;  // Tx engine address.
	logic [31:0]          txEngLen;   // Tx engine length.
	logic                 txEngDone;  // Tx engine done pulse.
	logic                 rxPktEnd;   // Rx packet end pulse.
	logic                 rxStoreEn;  // Rx ring may store.
	logic [3:0]           rxRdPtr;    // Rx ring read pointer.
	logic                 txToggle;   // Stalls the stream every other cycle.
	logic [31:0]          expTx;      // Next expected pattern word.
	int                   nTx;        // Pattern words taken.
	int                   num_errors; // Mismatches seen.
	int                   cmp_count;  // Comparisons made.

	ttcr_regs ttcr_regs_inst (
		.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .linkUp(linkUp), .connOn(connOn),
		.closeReq(closeReq), .txBeat(txBeat), .txReady(txReady),
		.rxBeat(rxBeat), .txEngStart(txEngStart), .txEngAddr(txEngAddr),
		.txEngLen(txEngLen), .txEngDone(txEngDone), .rxPktEnd(rxPktEnd),
		.rxStoreEn(rxStoreEn), .rxRdPtr(rxRdPtr)
	);

	// ----------------------------------------------------------------
	// Clock, stall pattern and stream monitor
	// ----------------------------------------------------------------
	// The clock toggles every half period.
	always #50 clk_sys = ~clk_sys;

	// Ready alternates while the toggle is on, so the stream sees stalls.
	always @(posedge clk_sys) txReady <= txToggle & ~txReady;

	// Every word taken must continue the incrementing pattern.
	// Sampled at the falling edge, where the handshake has settled.
	always @(negedge clk_sys) begin
		if (reset_n && txBeat.valid === 1'b1 && txReady === 1'b1) begin
			chk32("txBeat.data", expTx, txBeat.data);
			expTx = expTx + 32'h1;
			nTx = nTx + 1;
		end
	end

	// ----------------------------------------------------------------
	// Compare and access tasks
	// ----------------------------------------------------------------
	// Compares a word and counts the result.
	task automatic chk32(input string nm, input logic [31:0] e,
			input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk32

	// Compares a single bit and counts the result.
	task automatic chk1(input string nm, input logic e, input logic s);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, s);
		end
	endtask : chk1

	// One-cycle write strobe; the strobe drops at the taking edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr

	// One-cycle read; data are sampled in the following cycle only.
	task automatic chkRd(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		chk32($sformatf("reg %h", a), e, regRdData & m);
	endtask : chkRd

	// Sends one received word.
	task automatic rxw(input logic [31:0] d);
		@(posedge clk_sys);
		rxBeat <= '{1'b1, d};
		@(posedge clk_sys);
		rxBeat <= '{1'b0, 32'h0};
	endtask : rxw

	// Pulses the packet end input once.
	task automatic pkt;
		@(posedge clk_sys);
		rxPktEnd <= 1'b1;
		@(posedge clk_sys);
		rxPktEnd <= 1'b0;
	endtask : pkt

	// Waits, bounded, until the stream has delivered n words.
	task automatic waitTx(input int n);
		for (int i = 0; i < 200 && nTx < n; i++) @(posedge clk_sys);
	endtask : waitTx

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// Watchdog: the tests need well under 2000 cycles
	// ----------------------------------------------------------------
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		linkUp = 1'b1;
		connOn = 1'b0;
		txReady = 1'b0;
		rxBeat = '{1'b0, 32'h0};
		txEngDone = 1'b0;
		rxPktEnd = 1'b0;
		txToggle = 1'b0;
		expTx = 32'h0;
		nTx = 0;
		num_errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		// Status bits: link and connection state, passive close seen.
		chkRd(8'h00, 32'hFFFFFFFF, 32'h00010000);
		chkRd(8'h04, 32'h00000007, 32'h00000000);
		@(posedge clk_sys);
		connOn <= 1'b1;
		chkRd(8'h04, 32'h00000004, 32'h00000004);
		@(posedge clk_sys);
		connOn <= 1'b0;
		chkRd(8'h04, 32'h00000004, 32'h00000000);
		$display("test status done");
		// Send run of four words with stalls; no fifth word may follow.
		wr(8'h08, 32'h00000010);
		wr(8'h00, 32'h00000001);
		wr(8'h04, 32'h00000000);
		@(posedge clk_sys);
		txToggle <= 1'b1;
		waitTx(5);
		chk32("words", 32'h4, 32'(nTx));
		chkRd(8'h08, 32'hFFFFFFFF, 32'h00000010);
		wr(8'h00, 32'h00000001);
		chkRd(8'h08, 32'hFFFFFFFF, 32'h00000000);
		@(posedge clk_sys);
		expTx = 32'h0;
		nTx = 0;
		wr(8'h04, 32'h00000000);
		waitTx(5);
		chk32("words after clear", 32'h4, 32'(nTx));
		@(posedge clk_sys);
		txToggle <= 1'b0;
		$display("test pattern done");
		// Verification on: good words, then one bad word.
		wr(8'h00, 32'h00000001);
		wr(8'h04, 32'h00000002);
		rxw(32'h0);
		rxw(32'h1);
		rxw(32'h2);
		chkRd(8'h0C, 32'hFFFFFFFF, 32'h0000000C);
		chkRd(8'h04, 32'h00000002, 32'h00000000);
		rxw(32'h7);
		chkRd(8'h04, 32'h00000002, 32'h00000002);
		// Verification off: a bad word leaves the error clear.
		wr(8'h00, 32'h00000001);
		chkRd(8'h04, 32'h00000002, 32'h00000000);
		wr(8'h04, 32'h00000000);
		rxw(32'h5);
		chkRd(8'h04, 32'h00000002, 32'h00000000);
		$display("test verify done");
		// Full duplex start with 1 and active close with 3.
		@(posedge clk_sys);
		connOn <= 1'b1;
		wr(8'h08, 32'h00000008);
		wr(8'h00, 32'h00000001);
		wr(8'h04, 32'h00000001);
		chkRd(8'h04, 32'h00000005, 32'h00000005);
		wr(8'h04, 32'h00000003);
		@(negedge clk_sys);
		chk1("closeReq", 1'b1, closeReq);
		@(posedge clk_sys);
		connOn <= 1'b0;
		for (int i = 0; i < 10 && closeReq !== 1'b0; i++)
			@(negedge clk_sys);
		chk1("closeReq released", 1'b0, closeReq);
		// Full duplex start with 3 turns verification on.
		wr(8'h00, 32'h00000001);
		wr(8'h04, 32'h00000003);
		rxw(32'h9);
		chkRd(8'h04, 32'h00000003, 32'h00000003);
		$display("test duplex done");
		// Tx engine start, refusal while busy, finish and clear.
		wr(8'h20, 32'h00000100);
		chkRd(8'h20, 32'hFFFFFFFF, 32'h00000100);
		wr(8'h20, 32'h00000000);
		wr(8'h24, 32'h0000003C);
		chkRd(8'h24, 32'hFFFFFFFF, 32'h0000003C);
		wr(8'h28, 32'h00000001);
		@(negedge clk_sys);
		chk1("txEngStart", 1'b1, txEngStart);
		chk32("txEngLen", 32'h0000003C, txEngLen);
		chk32("txEngAddr", 32'h00000000, txEngAddr);
		wr(8'h28, 32'h00000001);
		@(negedge clk_sys);
		chk1("txEngStart busy", 1'b0, txEngStart);
		chkRd(8'h28, 32'h80000001, 32'h00000001);
		@(posedge clk_sys);
		txEngDone <= 1'b1;
		@(posedge clk_sys);
		txEngDone <= 1'b0;
		chkRd(8'h28, 32'h80000001, 32'h80000000);
		wr(8'h28, 32'h80000000);
		chkRd(8'h28, 32'h80000000, 32'h00000000);
		$display("test tx engine done");
		// Rx ring fills at a gap of eight, refuses, then frees a slot.
		repeat (8) pkt();
		chkRd(8'h30, 32'hFFFFFFFF, 32'h00010008);
		chk1("rxStoreEn full", 1'b0, rxStoreEn);
		pkt();
		chkRd(8'h30, 32'hFFFFFFFF, 32'h00010008);
		chkRd(8'h34, 32'h80000000, 32'h80000000);
		wr(8'h34, 32'h80000000);
		chkRd(8'h34, 32'h80000000, 32'h00000000);
		wr(8'h30, 32'h00000100);
		chkRd(8'h30, 32'hFFFFFFFF, 32'h00000108);
		chk1("rxStoreEn free", 1'b1, rxStoreEn);
		chk32("rxRdPtr", 32'h1, {28'h0, rxRdPtr});
		// Read pointer at 15, then wrapped to 0 makes the ring full again.
		wr(8'h30, 32'h00000F00);
		chkRd(8'h30, 32'hFFFFFFFF, 32'h00000F08);
		wr(8'h30, 32'h00000000);
		chkRd(8'h30, 32'hFFFFFFFF, 32'h00010008);
		// An unmapped address ignores writes and reads as zero.
		wr(8'h40, 32'h12345678);
		chkRd(8'h40, 32'hFFFFFFFF, 32'h00000000);
		$display("test rx ring done");
		end_of_test();
	end

endmodule : test_ttcr_regs

`default_nettype wire
